// >>> design/flash_status_map.svh
// constants for the status-read and deep power-down block
`ifndef FLASH_STATUS_MAP_SVH
`define FLASH_STATUS_MAP_SVH

// command opcodes
`define OP_STATUS_READ 8'hD7
`define OP_DPD_ENTER 8'hB9
`define OP_DPD_RESUME 8'hAB

// first status byte field positions
`define S1_READY_BIT 7
`define S1_COMPARE_BIT 6
`define S1_CAPACITY_HI 5
`define S1_CAPACITY_LO 2
`define S1_PROTECT_BIT 1
`define S1_PAGE_SIZE_BIT 0

// second status byte field positions
`define S2_READY_BIT 7
`define S2_SPARE_HI_BIT 6
`define S2_FAULT_BIT 5
`define S2_SPARE_LO_BIT 4
`define S2_LOCK_AVAIL_BIT 3
`define S2_PROG_HELD_B_BIT 2
`define S2_PROG_HELD_A_BIT 1
`define S2_ERASE_HELD_BIT 0

// reset values and the fixed spare-bit value
`define FAULT_FLAG_RESET 1'h0
`define COMPARE_FLAG_RESET 1'h0
`define SPARE_BIT_VALUE 1'h0

// timing: entry time in ns (default figure), clock period in ps
`define DPD_ENTRY_TIME_NS 3000
`define CLK_PERIOD_PS 5000

`endif

// >>> design/flash_status_pkg.sv
// types shared by the status-read and deep power-down block
package flash_status_pkg;

    typedef enum logic [1:0] {
        PWR_STANDBY,
        PWR_ENTERING,
        PWR_DEEP
    } pwr_state_t;

    typedef enum logic [2:0] {
        CMD_NONE,
        CMD_STATUS,
        CMD_DPD_ENTER,
        CMD_DPD_RESUME,
        CMD_OTHER
    } cmd_t;

    // level flags held by the command engines
    typedef struct packed {
        logic busy;
        logic protect_on;
        logic page_binary;
        logic lock_cmd_available_flag;
        logic prog_held_buffer_b;
        logic prog_held_buffer_a;
        logic erase_held_flag;
    } engine_flags_t;

    // one-cycle completion events from the command engines
    typedef struct packed {
        logic prog_end;
        logic erase_end;
        logic op_failed;
        logic op_aborted;
        logic compare_end;
        logic compare_differs;
    } engine_events_t;

endpackage : flash_status_pkg

// >>> design/pin_sync.sv
// two-flop synchroniser for pins that arrive from outside the clock domain
`timescale 1ns/1ps
module pin_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RESET_VAL = '0
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [W-1:0] pin,
    output logic [W-1:0] pin_s
);

    logic [W-1:0] meta_q;
    logic [W-1:0] meta_d;
    logic [W-1:0] sync_q;
    logic [W-1:0] sync_d;

    always_comb
    begin
        meta_d = pin;
        sync_d = meta_q;
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            meta_q <= RESET_VAL;
            sync_q <= RESET_VAL;
        end
        else
        begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign pin_s = sync_q;

endmodule : pin_sync

// >>> design/status_byte_tx.sv
// serialiser for the two alternating status bytes, msb first
`timescale 1ns/1ps
module status_byte_tx (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic restart,
    input wire logic shift_en,
    input wire logic [7:0] byte_one,
    input wire logic [7:0] byte_two,
    output logic so_bit
);

    logic [7:0] shreg_q;
    logic [7:0] shreg_d;
    logic [2:0] idx_q;
    logic [2:0] idx_d;
    logic sel_q;
    logic sel_d;
    logic so_q;
    logic so_d;
    logic [7:0] snap;

    always_comb
    begin
        shreg_d = shreg_q;
        idx_d = idx_q;
        sel_d = sel_q;
        so_d = so_q;
        snap = sel_q ? byte_two : byte_one;
        if (restart)
        begin
            idx_d = 3'h0;
            sel_d = 1'h0;
        end
        else if (shift_en)
        begin
            if (idx_q == 3'h0)
            begin
                // whole byte captured in the same cycle its first bit leaves
                so_d = snap[7];
                shreg_d = {snap[6:0], 1'h0};
                sel_d = ~sel_q;
            end
            else
            begin
                so_d = shreg_q[7];
                shreg_d = {shreg_q[6:0], 1'h0};
            end
            idx_d = idx_q + 3'h1;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            shreg_q <= 8'h00;
            idx_q <= 3'h0;
            sel_q <= 1'h0;
            so_q <= 1'h0;
        end
        else
        begin
            shreg_q <= shreg_d;
            idx_q <= idx_d;
            sel_q <= sel_d;
            so_q <= so_d;
        end
    end

    assign so_bit = so_q;

endmodule : status_byte_tx

// >>> design/flash_status_power.sv
// status word reporting and deep power-down control of the serial flash
`timescale 1ns/1ps
`include "flash_status_map.svh"

// Overview of operation
// - ready bit reads zero while busy
// - fault bit reports last erase/program error
// - failed byte during operation sets fault
// - aborted operations leave fault flag clear
// - fault flag refreshed after every erase or program
// - spare bits six and four read zero
// - bit three shows lockdown command available
// - buffer b held blocks buffer b writes
// - buffer a held blocks buffer a writes
// - bit zero shows erase suspended
// - compare flag holds latest compare mismatch
// - fixed four-bit capacity code in byte one
// - protection flag covers both enable methods
// - page size flag shows 256/264 organisation
// - standby when deselected and idle
// - deep power-down ignores all but resume
// - opcode B9h then deselect enters power-down
// - whole bytes after power-down opcode are ignored
// - partial or unaligned frames are ignored, power state unchanged
// - reset always starts in standby
// - power-down ignored while operation runs
// - opcode D7h streams both status bytes
// - deselect ends read, output released
// - opcode ABh then deselect resumes standby
module flash_status_power #(
    parameter int DPD_ENTRY_TIME_NS = `DPD_ENTRY_TIME_NS,
    // arbitrary value, stands in for the legacy capacity code
    parameter logic [3:0] CAPACITY_CODE = 4'hA
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic sck,
    input wire logic cs_n,
    input wire logic si,
    output logic so_o,
    output logic so_oe,
    input wire flash_status_pkg::engine_flags_t engine_flags,
    input wire flash_status_pkg::engine_events_t engine_events,
    output logic [7:0] status_word_second_byte,
    output logic buffer_a_write_block,
    output logic buffer_b_write_block,
    output logic standby,
    output logic deep_power_down
);

    // longest time, so the cycle count rounds down (never below one)
    localparam int DPD_RAW_CYCLES = (DPD_ENTRY_TIME_NS * 1000) / `CLK_PERIOD_PS;
    localparam int DPD_ENTRY_CYCLES = (DPD_RAW_CYCLES < 1) ? 1 : DPD_RAW_CYCLES;

    function automatic flash_status_pkg::cmd_t decode_opcode(input logic [7:0] op);
        flash_status_pkg::cmd_t c;
        case (op)
            `OP_STATUS_READ: c = flash_status_pkg::CMD_STATUS;
            `OP_DPD_ENTER: c = flash_status_pkg::CMD_DPD_ENTER;
            `OP_DPD_RESUME: c = flash_status_pkg::CMD_DPD_RESUME;
            default: c = flash_status_pkg::CMD_OTHER;
        endcase
        return c;
    endfunction : decode_opcode

    // ---- pin synchronisation: sck, cs_n, si ----
    logic [2:0] pins_s;
    logic sck_s, cs_n_s, si_s;

    pin_sync #(
        .W(3),
        .RESET_VAL(3'h2)
    ) u_pin_sync (
        .clk(clk),
        .rst_n(rst_n),
        .pin({sck, cs_n, si}),
        .pin_s(pins_s)
    );

    assign sck_s = pins_s[2];
    assign cs_n_s = pins_s[1];
    assign si_s = pins_s[0];

    // ---- edge detection on synchronised pins ----
    logic sck_prev_q, sck_prev_d;
    logic cs_prev_q, cs_prev_d;
    logic sck_rise, sck_fall, cs_rise, selected;

    always_comb
    begin
        sck_prev_d = sck_s;
        cs_prev_d = cs_n_s;
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            sck_prev_q <= 1'h0;
            cs_prev_q <= 1'h1;
        end
        else
        begin
            sck_prev_q <= sck_prev_d;
            cs_prev_q <= cs_prev_d;
        end
    end

    assign selected = ~cs_n_s;
    assign sck_rise = selected & sck_s & ~sck_prev_q;
    assign sck_fall = selected & ~sck_s & sck_prev_q;
    assign cs_rise = cs_n_s & ~cs_prev_q;

    // ---- frame decoder ----
    logic [6:0] op_shift_q, op_shift_d;
    logic [2:0] bit_cnt_q, bit_cnt_d;
    logic opcode_done_q, opcode_done_d;
    flash_status_pkg::cmd_t cmd_q, cmd_d;
    logic status_active_q, status_active_d;
    logic frame_whole;
    flash_status_pkg::pwr_state_t pwr_q, pwr_d;

    always_comb
    begin
        op_shift_d = op_shift_q;
        bit_cnt_d = bit_cnt_q;
        opcode_done_d = opcode_done_q;
        cmd_d = cmd_q;
        status_active_d = status_active_q;
        if (!selected)
        begin
            // deselect ends any read and forgets the frame
            op_shift_d = 7'h00;
            bit_cnt_d = 3'h0;
            opcode_done_d = 1'h0;
            cmd_d = flash_status_pkg::CMD_NONE;
            status_active_d = 1'h0;
        end
        else if (sck_rise)
        begin
            bit_cnt_d = bit_cnt_q + 3'h1;
            // after the opcode, further input bits are only counted
            if (!opcode_done_q)
            begin
                op_shift_d = {op_shift_q[5:0], si_s};
                if (bit_cnt_q == 3'h7)
                begin
                    opcode_done_d = 1'h1;
                    cmd_d = decode_opcode({op_shift_q, si_s});
                    // a status read is honoured only in standby, not while entering or in power-down
                    if (cmd_d == flash_status_pkg::CMD_STATUS &&
                        pwr_q == flash_status_pkg::PWR_STANDBY)
                    begin
                        status_active_d = 1'h1;
                    end
                end
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            op_shift_q <= 7'h00;
            bit_cnt_q <= 3'h0;
            opcode_done_q <= 1'h0;
            cmd_q <= flash_status_pkg::CMD_NONE;
            status_active_q <= 1'h0;
        end
        else
        begin
            op_shift_q <= op_shift_d;
            bit_cnt_q <= bit_cnt_d;
            opcode_done_q <= opcode_done_d;
            cmd_q <= cmd_d;
            status_active_q <= status_active_d;
        end
    end

    // whole opcode and a byte-aligned bit count at deselect
    assign frame_whole = opcode_done_q & (bit_cnt_q == 3'h0);

    // ---- power state ----
    logic [15:0] entry_cnt_q, entry_cnt_d;

    always_comb
    begin
        pwr_d = pwr_q;
        entry_cnt_d = entry_cnt_q;
        case (pwr_q)
            flash_status_pkg::PWR_STANDBY:
            begin
                // a running program or erase swallows the command
                if (cs_rise && frame_whole && cmd_q == flash_status_pkg::CMD_DPD_ENTER &&
                    !engine_flags.busy)
                begin
                    pwr_d = flash_status_pkg::PWR_ENTERING;
                    entry_cnt_d = 16'(DPD_ENTRY_CYCLES - 1);
                end
            end
            flash_status_pkg::PWR_ENTERING:
            begin
                // resume is not looked at until the entry delay expires
                if (entry_cnt_q == 16'h0000)
                begin
                    pwr_d = flash_status_pkg::PWR_DEEP;
                end
                else
                begin
                    entry_cnt_d = entry_cnt_q - 16'h0001;
                end
            end
            flash_status_pkg::PWR_DEEP:
            begin
                if (cs_rise && frame_whole &&
                    cmd_q == flash_status_pkg::CMD_DPD_RESUME)
                begin
                    pwr_d = flash_status_pkg::PWR_STANDBY;
                end
            end
            default:
            begin
                pwr_d = flash_status_pkg::PWR_STANDBY;
            end
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            pwr_q <= flash_status_pkg::PWR_STANDBY;
            entry_cnt_q <= 16'h0000;
        end
        else
        begin
            pwr_q <= pwr_d;
            entry_cnt_q <= entry_cnt_d;
        end
    end

    // ---- result flags kept for the command engines ----
    logic fault_q, fault_d;
    logic compare_q, compare_d;

    always_comb
    begin
        fault_d = fault_q;
        compare_d = compare_q;
        // every end of erase or program overwrites the previous outcome
        if (engine_events.prog_end || engine_events.erase_end)
        begin
            // an abort is not an error, so it clears the flag
            fault_d = engine_events.op_failed &
                      ~engine_events.op_aborted;
        end
        if (engine_events.compare_end)
        begin
            compare_d = engine_events.compare_differs;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            fault_q <= `FAULT_FLAG_RESET;
            compare_q <= `COMPARE_FLAG_RESET;
        end
        else
        begin
            fault_q <= fault_d;
            compare_q <= compare_d;
        end
    end

    // ---- status bytes ----
    logic [7:0] byte_one, byte_two;

    always_comb
    begin
        byte_one = 8'h00;
        byte_one[`S1_READY_BIT] = ~engine_flags.busy;
        byte_one[`S1_COMPARE_BIT] = compare_q;
        byte_one[`S1_CAPACITY_HI:`S1_CAPACITY_LO] = CAPACITY_CODE;
        byte_one[`S1_PROTECT_BIT] = engine_flags.protect_on;
        byte_one[`S1_PAGE_SIZE_BIT] = engine_flags.page_binary;
        byte_two = 8'h00;
        byte_two[`S2_READY_BIT] = ~engine_flags.busy;
        byte_two[`S2_SPARE_HI_BIT] = `SPARE_BIT_VALUE;
        byte_two[`S2_FAULT_BIT] = fault_q;
        byte_two[`S2_SPARE_LO_BIT] = `SPARE_BIT_VALUE;
        byte_two[`S2_LOCK_AVAIL_BIT] = engine_flags.lock_cmd_available_flag;
        byte_two[`S2_PROG_HELD_B_BIT] = engine_flags.prog_held_buffer_b;
        byte_two[`S2_PROG_HELD_A_BIT] = engine_flags.prog_held_buffer_a;
        byte_two[`S2_ERASE_HELD_BIT] = engine_flags.erase_held_flag;
    end

    // registered copy so software-facing data comes from flops
    logic [7:0] byte_two_q;

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            byte_two_q <= 8'h80;
        end
        else
        begin
            byte_two_q <= byte_two;
        end
    end

    status_byte_tx u_status_tx (
        .clk(clk),
        .rst_n(rst_n),
        .restart(~status_active_q),
        .shift_en(status_active_q & sck_fall),
        .byte_one(byte_one),
        .byte_two(byte_two),
        .so_bit(so_o)
    );

    // released at once on deselect; the host samples on rising sck
    assign so_oe = status_active_q & selected;
    assign status_word_second_byte = byte_two_q;
    // command decoders outside use these to drop buffer writes
    assign buffer_a_write_block = engine_flags.prog_held_buffer_a;
    assign buffer_b_write_block = engine_flags.prog_held_buffer_b;
    assign standby = (pwr_q == flash_status_pkg::PWR_STANDBY) & cs_n_s &
                     ~engine_flags.busy;
    assign deep_power_down = (pwr_q == flash_status_pkg::PWR_DEEP);

endmodule : flash_status_power

// >>> dv/flash_status_power_properties.sv
// assertion checker for the status and power-down block
`timescale 1ns/1ps
module flash_status_power_checker #(
    parameter int DPD_ENTRY_TIME_NS = 3000
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic sck,
    input wire logic cs_n,
    input wire logic si,
    input wire logic so_o,
    input wire logic so_oe,
    input wire flash_status_pkg::engine_flags_t engine_flags,
    input wire flash_status_pkg::engine_events_t engine_events,
    input wire logic [7:0] status_word_second_byte,
    input wire logic buffer_a_write_block,
    input wire logic buffer_b_write_block,
    input wire logic standby,
    input wire logic deep_power_down
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    logic op_end;
    assign op_end = engine_events.prog_end | engine_events.erase_end;

    property p_spare;
        status_word_second_byte[6] == 1'b0 && status_word_second_byte[4] == 1'b0;
    endproperty
    a_spare: assert property (p_spare) else $error("spare bits not zero");
    property p_ready;
        $stable(engine_flags.busy) |-> status_word_second_byte[7] == !engine_flags.busy;
    endproperty
    a_ready: assert property (p_ready) else $error("ready bit wrong");
    property p_blk_a;
        buffer_a_write_block == engine_flags.prog_held_buffer_a;
    endproperty
    a_blk_a: assert property (p_blk_a) else $error("buffer a block wrong");
    property p_blk_b;
        buffer_b_write_block == engine_flags.prog_held_buffer_b;
    endproperty
    a_blk_b: assert property (p_blk_b) else $error("buffer b block wrong");
    property p_fault_set;
        op_end && engine_events.op_failed && !engine_events.op_aborted
            |-> ##[1:2] status_word_second_byte[5];
    endproperty
    a_fault_set: assert property (p_fault_set) else $error("fault not set");
    property p_fault_clr;
        op_end && engine_events.op_aborted |-> ##[1:2] !status_word_second_byte[5];
    endproperty
    a_fault_clr: assert property (p_fault_clr) else $error("fault set on abort");
    property p_low_flags;
        engine_flags[3:0] == $past(engine_flags[3:0])
            |-> status_word_second_byte[3:0] == engine_flags[3:0];
    endproperty
    a_low_flags: assert property (p_low_flags) else $error("low flags wrong");
    property p_deep_quiet;
        deep_power_down |-> !so_oe;
    endproperty
    a_deep_quiet: assert property (p_deep_quiet) else $error("output in power-down");
    property p_standby;
        standby |-> $past(cs_n, 2) && !engine_flags.busy && !deep_power_down;
    endproperty
    a_standby: assert property (p_standby) else $error("standby while active");
    property p_entry;
        $rose(deep_power_down) |-> $past(cs_n, 20);
    endproperty
    a_entry: assert property (p_entry) else $error("power-down too early");
endmodule : flash_status_power_checker

bind flash_status_power flash_status_power_checker #(
    .DPD_ENTRY_TIME_NS(DPD_ENTRY_TIME_NS)
) i_flash_status_power_checker (
    .clk, .rst_n, .sck, .cs_n, .si, .so_o, .so_oe, .engine_flags, .engine_events,
    .status_word_second_byte, .buffer_a_write_block, .buffer_b_write_block,
    .standby, .deep_power_down
);

// >>> dv/spi_host_model.sv
// host controller model driving command frames on the serial link
`timescale 1ns/1ps
module spi_host_model (
    output logic sck,
    output logic cs_n,
    output logic si,
    input wire logic so_o,
    input wire logic so_oe
);
    logic so_last = 1'b0;
    logic so_line;
    initial
    begin
        sck = 1'b0;
        cs_n = 1'b1;
        si = 1'b0;
    end
    // no pull on the line: released, it toggles so a stale bit never reads right
    assign so_line = so_oe ? so_o : ~so_last;
    always @(posedge sck)
        so_last <= so_line;

    // mode 0, msb first; sck stands low between frames
    task automatic frame(input logic [31:0] data, input int n, output logic [31:0] rx);
        rx = '0;
        // off the clk grid, so no sck or cs_n edge meets a clk edge
        #0.3;
        cs_n = 1'b0;
        for (int i = 0; i < n; i++)
        begin
            si = data[31 - i];
            #24 sck = 1'b1;
            rx = {rx[30:0], so_line};
            #24 sck = 1'b0;
        end
        #24 cs_n = 1'b1;
        si = ~si;
        #50;
    endtask : frame
endmodule : spi_host_model

// >>> dv/tb_flash_status_power.sv
// testbench for the status and power-down block
`timescale 1ns/1ps
module tb_flash_status_power;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic sck, cs_n, si, so_o, so_oe, standby, deep_power_down, blk_a, blk_b;
    logic oe_seen = 1'b0;
    logic oe_clr = 1'h0;
    logic [7:0] st2;
    logic [31:0] rx;
    flash_status_pkg::engine_flags_t flags = '0;
    flash_status_pkg::engine_events_t events = '0;
    int errors = 0;
    int checks = 0;
    int cycles = 0;

    always #2.5 clk = ~clk;

    // 100 ns entry time keeps the power-down wait at 20 cycles
    flash_status_power #(.DPD_ENTRY_TIME_NS(100)) i_flash_status_power (
        .clk(clk), .rst_n(rst_n), .sck(sck), .cs_n(cs_n), .si(si),
        .so_o(so_o), .so_oe(so_oe), .engine_flags(flags), .engine_events(events),
        .status_word_second_byte(st2), .buffer_a_write_block(blk_a),
        .buffer_b_write_block(blk_b), .standby(standby), .deep_power_down(deep_power_down)
    );
    spi_host_model i_spi_host_model (.sck, .cs_n, .si, .so_o, .so_oe);

    always @(posedge clk)
        if (oe_clr)
            oe_seen <= 1'h0;
        else if (so_oe)
            oe_seen <= 1'h1;

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            errors++;
            $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick

    task automatic pulse(input logic [5:0] ev);
        events = ev;
        tick(1);
        events = '0;
        // a gap cycle, so back-to-back pulses never rewrite events at once
        tick(1);
    endtask : pulse

    task automatic stop_test();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : stop_test

    task automatic t_reset();
        chk(deep_power_down, 1'b0);
        chk(st2, 8'h80);
        chk(standby, 1'b1);
    endtask : t_reset

    // flag order: busy protect page lock held_b held_a erase_held
    task automatic t_status();
        flags = 7'b0111101;
        pulse(6'b000011);
        pulse(6'b101000);
        tick(3);
        chk(st2, 8'hAD);
        chk({blk_a, blk_b}, 2'b01);
        i_spi_host_model.frame(32'hD7000000, 32, rx);
        tick(1);
        chk(rx[23:0], 24'hEBADEB);
        flags = 7'b1110110;
        pulse(6'b011100);
        pulse(6'b000010);
        tick(3);
        chk(st2, 8'h06);
        chk({blk_a, blk_b}, 2'b11);
        i_spi_host_model.frame(32'hD7000000, 28, rx);
        tick(1);
        chk(rx[19:0], 20'h2B062);
        chk(oe_seen & so_oe, 1'b0);
    endtask : t_status

    // host keeps clocking status while the operation ends mid-stream
    task automatic t_poll();
        flags = 7'h40;
        fork
            i_spi_host_model.frame(32'hD7000000, 32, rx);
            begin
                tick(200);
                flags = '0;
            end
        join
        tick(1);
        chk({rx[23], rx[15], rx[7]}, 3'h1);
    endtask : t_poll

    task automatic t_power();
        flags = 7'b1000000;
        i_spi_host_model.frame(32'hB9000000, 8, rx);
        tick(40);
        chk(deep_power_down, 1'b0);
        flags = '0;
        i_spi_host_model.frame(32'hB9F00000, 12, rx);
        tick(40);
        chk(deep_power_down, 1'b0);
        i_spi_host_model.frame(32'hB9A50000, 16, rx);
        tick(5);
        chk(deep_power_down, 1'b0);
        tick(30);
        chk(deep_power_down, 1'b1);
        chk(standby, 1'b0);
        oe_clr = 1'h1;
        tick(1);
        oe_clr = 1'h0;
        i_spi_host_model.frame(32'hD7000000, 24, rx);
        tick(2);
        chk(oe_seen, 1'b0);
        chk(deep_power_down, 1'b1);
        i_spi_host_model.frame(32'hAB000000, 8, rx);
        tick(10);
        chk(deep_power_down, 1'b0);
        chk(standby, 1'b1);
        i_spi_host_model.frame(32'hD7000000, 24, rx);
        tick(1);
        chk(rx[15:0], 16'hA880);
    endtask : t_power

    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            errors++;
            stop_test();
        end
    end

    initial
    begin
        tick(2);
        rst_n = 1'b1;
        tick(4);
        t_reset();
        t_status();
        t_poll();
        t_power();
        stop_test();
    end
endmodule : tb_flash_status_power
